// ==== hdl/ccr_regs.sv ====
// compression code, remap targets and roi box register bank
// assumes host port and pipeline strobes share clk_in; switches are async
`timescale 1ns/10ps
module ccr_regs (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire ccr_pkg::ccr_req_s req_in,
  input wire logic frame_start_in,
  input wire logic [4:0] auto_code_in,
  input wire logic agc_switch_in,
  input wire logic remap_switch_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  output logic [4:0] comp_code_out,
  output logic [4:0] auto_ceiling_out,
  output logic auto_update_out,
  output ccr_pkg::ccr_tgt_s targets_out,
  output logic targets_active_out,
  output ccr_pkg::ccr_roi_s roi_out
);
  import ccr_pkg::*;

  function automatic logic [4:0] clamp_code(input logic [4:0] code,
                                            input logic [4:0] ceil);
    clamp_code = (code > ceil) ? ceil : code;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // switch synchronisers
  logic [1:0] agc_sync_reg;
  logic [1:0] remap_sync_reg;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      agc_sync_reg <= 2'h0;
      remap_sync_reg <= 2'h0;
    end else begin
      agc_sync_reg <= {agc_sync_reg[0], agc_switch_in};
      remap_sync_reg <= {remap_sync_reg[0], remap_switch_in};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register file and read port
  logic [15:0] comp_reg, comp_next;
  logic [15:0] bw_reg, bw_next;
  logic [15:0] col_reg, col_next;
  logic [15:0] row_reg, row_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  always_comb begin
    comp_next = comp_reg;
    bw_next = bw_reg;
    col_next = col_reg;
    row_next = row_reg;
    rdata_next = rdata_reg;
    rvalid_next = req_in.rd;
    if (req_in.wr) begin
      if (req_in.addr == CCR_OFF_COMP) begin
        comp_next = req_in.wdata;
      end else if (req_in.addr == CCR_OFF_BW) begin
        bw_next = req_in.wdata;
      end else if (req_in.addr == CCR_OFF_COL) begin
        col_next = req_in.wdata;
      end else if (req_in.addr == CCR_OFF_ROW) begin
        row_next = req_in.wdata;
      end
    end
    if (req_in.rd) begin
      if (req_in.addr == CCR_OFF_COMP) begin
        rdata_next = comp_reg;
      end else if (req_in.addr == CCR_OFF_BW) begin
        rdata_next = bw_reg;
      end else if (req_in.addr == CCR_OFF_COL) begin
        rdata_next = col_reg;
      end else if (req_in.addr == CCR_OFF_ROW) begin
        rdata_next = row_reg;
      end else begin
        rdata_next = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      comp_reg <= CCR_RST_COMP;
      bw_reg <= CCR_RST_OTHER;
      col_reg <= CCR_RST_OTHER;
      row_reg <= CCR_RST_OTHER;
      rdata_reg <= CCR_RST_OTHER;
      rvalid_reg <= 1'b0;
    end else begin
      comp_reg <= comp_next;
      bw_reg <= bw_next;
      col_reg <= col_next;
      row_reg <= row_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // reserved bit stored for readback only, it steers nothing
  logic [3:0] interval;
  logic [4:0] ceiling_field;
  logic [4:0] manual_code;
  logic manual_en;
  assign interval = comp_reg[CCR_POS_IVL_HI:CCR_POS_IVL_LO];
  assign ceiling_field = comp_reg[CCR_POS_CEIL_HI:CCR_POS_CEIL_LO];
  assign manual_code = comp_reg[CCR_POS_MAN_HI:CCR_POS_MAN_LO];
  assign manual_en = comp_reg[CCR_POS_MAN_EN];

  //////////////////////////////////////////////////////////////////////
  // frame-aligned ceiling
  logic [4:0] ceiling_applied;
  ccr_frame_hold #(
    .WIDTH(5),
    .RESET_VALUE(CCR_RST_CEIL)
  ) u_ceiling_hold (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .load_in(frame_start_in),
    .data_in(ceiling_field),
    .data_out(ceiling_applied)
  );

  //////////////////////////////////////////////////////////////////////
  // automatic update cadence and code selection
  logic [3:0] frame_cnt_reg, frame_cnt_next;
  logic update_reg, update_next;
  logic [4:0] auto_reg, auto_next;
  logic [4:0] code_reg, code_next;
  logic [4:0] ceil_out_reg;

  always_comb begin
    frame_cnt_next = frame_cnt_reg;
    update_next = 1'b0;
    auto_next = auto_reg;
    // one update per interval frames; zero treated as every frame
    if (frame_start_in) begin
      if ((frame_cnt_reg + 4'h1) >= interval) begin
        frame_cnt_next = 4'h0;
        update_next = 1'b1;
      end else begin
        frame_cnt_next = frame_cnt_reg + 4'h1;
      end
    end
    // automatic choice capped by applied ceiling
    if (update_reg) begin
      auto_next = clamp_code(auto_code_in, ceiling_applied);
    end
    // manual code goes out with no frame wait
    code_next = manual_en ? manual_code : auto_reg;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_cnt_reg <= 4'h0;
      update_reg <= 1'b0;
      auto_reg <= CCR_RST_CEIL;
      code_reg <= CCR_RST_CEIL;
      ceil_out_reg <= CCR_RST_CEIL;
    end else begin
      frame_cnt_reg <= frame_cnt_next;
      update_reg <= update_next;
      auto_reg <= auto_next;
      code_reg <= code_next;
      ceil_out_reg <= ceiling_applied;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // remap targets and roi box
  ccr_tgt_s tgt_reg, tgt_next;
  ccr_roi_s roi_reg, roi_next;
  logic active_reg, active_next;

  always_comb begin
    // targets only reach the remap when both switches select it
    active_next = agc_sync_reg[1] & remap_sync_reg[1];
    tgt_next = '0;
    if (active_next) begin
      // black count in units of 64
      tgt_next.black = {bw_reg[15:8], CCR_BLACK_PAD};
      // white count in units of 256
      tgt_next.white = {bw_reg[7:0], CCR_WHITE_PAD};
    end
    // column end on multiple of 8
    roi_next.col_end = {col_reg[15:8], CCR_COL_PAD};
    // column start on multiple of 8
    roi_next.col_start = {col_reg[7:0], CCR_COL_PAD};
    // row end on multiple of 4
    roi_next.row_end = {row_reg[15:8], CCR_ROW_PAD};
    // row start on multiple of 4
    roi_next.row_start = {row_reg[7:0], CCR_ROW_PAD};
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgt_reg <= '0;
      roi_reg <= '0;
      active_reg <= 1'b0;
    end else begin
      tgt_reg <= tgt_next;
      roi_reg <= roi_next;
      active_reg <= active_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign rvalid_out = rvalid_reg;
  assign comp_code_out = code_reg;
  assign auto_ceiling_out = ceil_out_reg;
  assign auto_update_out = update_reg;
  assign targets_out = tgt_reg;
  assign targets_active_out = active_reg;
  assign roi_out = roi_reg;

  //////////////////////////////////////////////////////////////////////
  // checks
  AST_UPDATE_ON_FRAME: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    auto_update_out |-> $past(frame_start_in))
    else $error("automatic update without a frame start");

  AST_CEILING_FRAME: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $changed(ceiling_applied) |-> $past(frame_start_in))
    else $error("ceiling changed away from a frame start");

  AST_AUTO_CAPPED: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    update_reg |=> auto_reg <= $past(ceiling_applied))
    else $error("automatic code above ceiling");

  AST_MANUAL_IMMEDIATE: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.wr && req_in.addr == CCR_OFF_COMP && req_in.wdata[0])
    ##1 !(req_in.wr && req_in.addr == CCR_OFF_COMP)
    |-> ##1 comp_code_out == $past(req_in.wdata[5:1], 2))
    else $error("manual code not applied two cycles after write");

  AST_AUTO_SELECT: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !manual_en |=> comp_code_out == $past(auto_reg))
    else $error("automatic value not selected");

  AST_BLACK_SCALE: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    active_next |=> targets_out.black == 14'($past(bw_reg[15:8]) * 64))
    else $error("black target scaling wrong");

  AST_WHITE_SCALE: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    active_next |=> targets_out.white == 16'($past(bw_reg[7:0]) * 256))
    else $error("white target scaling wrong");

  AST_TARGETS_GATED: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !targets_active_out |-> targets_out == '0)
    else $error("targets visible while remap inactive");

  AST_COL_ALIGN: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    roi_out.col_end[2:0] == 3'h0 && roi_out.col_start[2:0] == 3'h0)
    else $error("column bound not a multiple of 8");

  AST_ROW_TRACK: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> roi_out.row_end == {$past(row_reg[15:8]), 2'h0})
    else $error("row end does not follow register");

  AST_READBACK: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.rd && req_in.addr == CCR_OFF_BW) |=>
    rvalid_out && rdata_out == $past(bw_reg))
    else $error("readback mismatch");
endmodule

// ==== hdl/ccr_pkg.sv ====
// constants, field layout and carriers for the compression and roi bank
// assumes one pipeline clock and 8-bit register indices
//
// Operation
// - bits 14:11 set frames between automatic code updates, default 2
// - bits 10:6 cap the automatic code, applied from next frame
// - bits 5:1 hold the manual code; 3 and below linear, 31 maximum
// - manual code writes take effect at once, mid-frame allowed
// - bit 0 high selects manual code, low selects automatic code
// - black target count is bits 15:8 times 64
// - white target count is bits 7:0 times 256
// - targets matter only with gain control and linear remap selected
// - column end is bits 15:8 with three low zero bits
// - column start is bits 7:0 with three low zero bits
// - row end is bits 15:8 with two low zero bits
// - row start is bits 7:0 with two low zero bits
package ccr_pkg;
  localparam logic [7:0] CCR_OFF_COMP = 8'h04;
  localparam logic [7:0] CCR_OFF_BW = 8'h05;
  localparam logic [7:0] CCR_OFF_COL = 8'h06;
  localparam logic [7:0] CCR_OFF_ROW = 8'h07;
  localparam int CCR_POS_RSVD = 15;
  localparam int CCR_POS_IVL_HI = 14;
  localparam int CCR_POS_IVL_LO = 11;
  localparam int CCR_POS_CEIL_HI = 10;
  localparam int CCR_POS_CEIL_LO = 6;
  localparam int CCR_POS_MAN_HI = 5;
  localparam int CCR_POS_MAN_LO = 1;
  localparam int CCR_POS_MAN_EN = 0;
  localparam logic [15:0] CCR_RST_COMP = 16'h1000;
  localparam logic [15:0] CCR_RST_OTHER = 16'h0000;
  localparam logic [4:0] CCR_RST_CEIL = 5'h00;
  localparam logic [5:0] CCR_BLACK_PAD = 6'h00;
  localparam logic [7:0] CCR_WHITE_PAD = 8'h00;
  localparam logic [2:0] CCR_COL_PAD = 3'h0;
  localparam logic [1:0] CCR_ROW_PAD = 2'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ccr_req_s;

  typedef struct packed {
    logic [10:0] col_start;
    logic [10:0] col_end;
    logic [9:0] row_start;
    logic [9:0] row_end;
  } ccr_roi_s;

  typedef struct packed {
    logic [13:0] black;
    logic [15:0] white;
  } ccr_tgt_s;
endpackage

// ==== hdl/ccr_frame_hold.sv ====
// holding register that only loads on a frame boundary pulse
// assumes load_in is a one-cycle pulse on the pipeline clock
`timescale 1ns/10ps
module ccr_frame_hold #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out
);
  logic [WIDTH-1:0] hold_reg;
  logic [WIDTH-1:0] hold_next;

  always_comb begin
    hold_next = hold_reg;
    if (load_in) begin
      hold_next = data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_reg <= RESET_VALUE;
    end else begin
      hold_reg <= hold_next;
    end
  end

  assign data_out = hold_reg;
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the compression code and roi register bank
// assumes reads answer one cycle after the strobe, inputs move at negedge
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import ccr_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  ccr_req_s req = '0;
  logic frame_start_in = 1'b0;
  logic [4:0] auto_code_in = 5'h00;
  logic agc_switch_in = 1'b0;
  logic remap_switch_in = 1'b0;
  logic [15:0] rdata_out;
  logic rvalid_out;
  logic [4:0] comp_code_out;
  logic [4:0] auto_ceiling_out;
  logic auto_update_out;
  ccr_tgt_s targets_out;
  logic targets_active_out;
  ccr_roi_s roi_out;
  int err_count = 0;
  int checked = 0;
  ccr_regs ccr_regs_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req),
    .frame_start_in(frame_start_in), .auto_code_in(auto_code_in),
    .agc_switch_in(agc_switch_in), .remap_switch_in(remap_switch_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .comp_code_out(comp_code_out), .auto_ceiling_out(auto_ceiling_out),
    .auto_update_out(auto_update_out), .targets_out(targets_out),
    .targets_active_out(targets_active_out), .roi_out(roi_out));
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("counts: %0d compared, %0d mismatched", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk_in);
    req.wr = 1'b0;
    // spare cycle so a following call never retoggles the strobe at once
    @(negedge clk_in);
  endtask
  // bounded wait: a missing answer ends the run
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
    int n;
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_in);
    req.rd = 1'b0;
    for (n = 0; n < 4; n++) begin
      if (rvalid_out === 1'b1) break;
      @(negedge clk_in);
    end
    if (n == 4) begin
      err_count++;
      $display("CHECK FAILED rvalid expected 1 seen timeout");
      complete_run();
    end else begin
      `CHK("rdata", e, rdata_out)
      @(negedge clk_in);
    end
  endtask
  // frame starts five cycles apart, update pulses counted
  task automatic frames(input int cnt, inout int ups);
    repeat (cnt) begin
      frame_start_in = 1'b1;
      @(negedge clk_in);
      frame_start_in = 1'b0;
      // the update pulse stands only in the cycle right after the start
      repeat (4) begin
        if (auto_update_out === 1'b1) ups++;
        @(negedge clk_in);
      end
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK("comp_code", 5'h00, comp_code_out)
    chk_reg(8'h04, 16'h1000); // default interval
    chk_reg(8'h05, 16'h0000);
    chk_reg(8'h06, 16'h0000);
    chk_reg(8'h07, 16'h0000);
    chk_reg(8'h08, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_auto();
    int ups;
    ups = 0;
    auto_code_in = 5'h14;
    wr_reg(8'h04, 16'h1a80);
    repeat (2) @(negedge clk_in);
    `CHK("ceiling early", 5'h00, auto_ceiling_out)
    frames(1, ups);
    `CHK("ceiling", 5'h0a, auto_ceiling_out)
    frames(5, ups);
    `CHK("updates", 2, ups)
    `CHK("comp_code clamp", 5'h0a, comp_code_out)
    auto_code_in = 5'h07;
    frames(3, ups);
    `CHK("comp_code auto", 5'h07, comp_code_out)
    `CHK("updates", 3, ups)
    $display("test auto done");
  endtask
  task automatic t_manual();
    wr_reg(8'h04, 16'h1abf);
    repeat (2) @(negedge clk_in);
    `CHK("comp_code max", 5'h1f, comp_code_out)
    wr_reg(8'h04, 16'h1a87);
    repeat (2) @(negedge clk_in);
    `CHK("comp_code low", 5'h03, comp_code_out)
    chk_reg(8'h04, 16'h1a87);
    wr_reg(8'h04, 16'h1a80);
    repeat (2) @(negedge clk_in);
    `CHK("comp_code back", 5'h07, comp_code_out)
    $display("test manual done");
  endtask
  task automatic t_targets();
    wr_reg(8'h05, 16'h3c5a);
    agc_switch_in = 1'b1;
    repeat (8) @(negedge clk_in);
    `CHK("active one", 1'b0, targets_active_out)
    `CHK("targets off", 30'h0, targets_out)
    remap_switch_in = 1'b1;
    repeat (8) @(negedge clk_in);
    `CHK("active", 1'b1, targets_active_out)
    `CHK("black", {8'h3c, 6'h00}, targets_out.black)
    `CHK("white", {8'h5a, 8'h00}, targets_out.white)
    agc_switch_in = 1'b0;
    repeat (8) @(negedge clk_in);
    `CHK("targets gone", 30'h0, targets_out)
    chk_reg(8'h05, 16'h3c5a);
    $display("test targets done");
  endtask
  task automatic t_roi();
    wr_reg(8'h06, 16'hab12);
    wr_reg(8'h07, 16'hc734);
    wr_reg(8'h02, 16'hffff);
    repeat (2) @(negedge clk_in);
    `CHK("col_end", {8'hab, 3'h0}, roi_out.col_end)
    `CHK("col_start", {8'h12, 3'h0}, roi_out.col_start)
    `CHK("row_end", {8'hc7, 2'h0}, roi_out.row_end)
    `CHK("row_start", {8'h34, 2'h0}, roi_out.row_start)
    chk_reg(8'h06, 16'hab12);
    chk_reg(8'h07, 16'hc734);
    chk_reg(8'h02, 16'h0000);
    $display("test roi done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_auto();
    t_manual();
    t_targets();
    t_roi();
    complete_run();
  end
endmodule
